// ---- dv/aosr_regs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module aosr_regs_monitor
  import aosr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [8:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        cal_done_i,
  input wire logic        pll_cal_done_i,
  input wire logic        pll_drift_low_i,
  input wire logic        pll_drift_high_i,
  input wire logic [1:0]  chan_sel_i,
  input wire logic [10:0] chan_offset_o,
  input wire logic [1:0]  step_sel_o,
  input wire logic        irq_o
);
  // ----------------------------------------
  // Register bus answers
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_IDENT_LOW: assert property (rd_i && addr_i == ADDR_IDENT_LOW |=>
    rdata_o == DEVICE_IDENT[7:0]) else $error("ident low byte wrong");
  AST_IDENT_HIGH: assert property (rd_i && addr_i == ADDR_IDENT_HIGH |=>
    rdata_o == DEVICE_IDENT[15:8]) else $error("ident high byte wrong");
  AST_PLL_RSVD: assert property (rd_i && addr_i == ADDR_PLL_STATUS |=>
    (rdata_o & 8'hD9) == (PLL_RSVD_VALUE & 8'hD9)) else $error("pll factory bits moved");
  AST_STEP_FIELD: assert property (wr_i && addr_i == ADDR_STEP_CTRL |=>
    {3'b000, step_sel_o, 3'b000} == ($past(wdata_i) & 8'h18)) else $error("step not taken");
  // Only a step write may move the shared step
  AST_STEP_HOLD: assert property (!(wr_i && addr_i == ADDR_STEP_CTRL) |=>
    $stable(step_sel_o)) else $error("step moved without write");
  AST_OFFSET_KEEP: assert property (wr_i && addr_i inside {[ADDR_CH4_OFFSET:ADDR_CH7_OFFSET]}
    ##1 rd_i && addr_i == $past(addr_i) |=> rdata_o == $past(wdata_i, 2))
    else $error("offset readback wrong");
  // Held inputs only, status passes a register stage
  AST_DRIFT_LOW: assert property (rd_i && addr_i == ADDR_PLL_STATUS && !$past(rst_i)
    && $stable(pll_drift_low_i) |=> rdata_o[2] == $past(pll_drift_low_i))
    else $error("drift low flag wrong");
  AST_CAL_DONE: assert property (rd_i && addr_i == ADDR_CAL_STATUS && !$past(rst_i)
    && $stable(cal_done_i) |=> rdata_o[7] == $past(cal_done_i)) else $error("cal flag wrong");
endmodule : aosr_regs_monitor
`default_nettype wire

// ---- dv/aosr_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module aosr_regs_tb
  import aosr_pkg::*;
;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic [8:0]  addr_i = '0;
  logic [7:0]  wdata_i = '0;
  logic        wr_i = 0;
  logic        rd_i = 0;
  logic [3:0]  ev = '0;
  logic [1:0]  chan_sel_i = '0;
  logic [7:0]  rdata_o;
  logic [10:0] chan_offset_o;
  logic [1:0]  step_sel_o;
  logic        irq_o;
  int          err_total = 0;
  int          check_count = 0;
  aosr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cal_done_i(ev[0]), .pll_cal_done_i(ev[1]),
    .pll_drift_low_i(ev[2]), .pll_drift_high_i(ev[3]), .chan_sel_i(chan_sel_i),
    .chan_offset_o(chan_offset_o), .step_sel_o(step_sel_o), .irq_o(irq_o));
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
  endtask : wr
  // Read follows a write with no gap, it also drops the write strobe
  task automatic rc(input string n, input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, {3'b000, e}, {3'b000, rdata_o});
  endtask : rc
  task automatic close_out();
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [8:0] a[10] = '{ADDR_CH4_OFFSET, ADDR_CH5_OFFSET, ADDR_CH6_OFFSET, ADDR_CH7_OFFSET,
      ADDR_STEP_CTRL, ADDR_CAL_STATUS, ADDR_PLL_STATUS, ADDR_IRQ_MASK, ADDR_IDENT_LOW,
      ADDR_IDENT_HIGH};
    logic [7:0] e[10] = '{8'h00, 8'h00, 8'h00, 8'h00, STEP_CTRL_RESET, 8'h00, 8'h00, 8'h00,
      DEVICE_IDENT[7:0], DEVICE_IDENT[15:8]};
    for (int i = 0; i < 10; i++) rc("reset_value", a[i], e[i]);
  endtask : t_reset
  task automatic t_offset();
    logic [7:0] c[4] = '{8'h80, 8'h7F, 8'hFF, 8'h01};
    for (int ch = 0; ch < 4; ch++) begin
      for (int s = 0; s < 4; s++) begin
        wr(ADDR_CH4_OFFSET + 9'(ch), c[s]);
        rc("offset_reg", ADDR_CH4_OFFSET + 9'(ch), c[s]);
        wr(ADDR_STEP_CTRL, {3'b010, 2'(s), 3'b111});
        // Write strobe is one cycle long
        @(posedge clk_i);
        wr_i <= 1'b0;
        chan_sel_i <= 2'(ch);
        repeat (2) @(posedge clk_i);
        #1 chk("step_sel", 11'(s), 11'(step_sel_o));
        chk("chan_offset", {{3{c[s][7]}}, c[s]} << s, chan_offset_o);
      end
    end
  endtask : t_offset
  task automatic t_ro();
    logic [8:0] a[5] = '{ADDR_CAL_STATUS, ADDR_PLL_STATUS, ADDR_IDENT_LOW, ADDR_IDENT_HIGH,
      9'h1FF};
    logic [7:0] e[5] = '{8'h00, 8'h00, DEVICE_IDENT[7:0], DEVICE_IDENT[15:8], 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(a[i], 8'hFF);
      rc("read_only", a[i], e[i]);
    end
  endtask : t_ro
  task automatic t_status();
    logic [8:0] a[4] = '{ADDR_CAL_STATUS, ADDR_PLL_STATUS, ADDR_PLL_STATUS, ADDR_PLL_STATUS};
    logic [7:0] e[4] = '{8'h80, 8'h20, 8'h04, 8'h02};
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_IRQ_MASK, 8'h00);
      ev <= 4'b0001 << b;
      rc("status_bit", a[b], e[b]);
      rc("irq_status", ADDR_IRQ_STATUS, 8'h01 << b);
      chk("irq_masked", 11'h000, 11'(irq_o));
      wr(ADDR_IRQ_MASK, 8'h01 << b);
      rc("irq_mask", ADDR_IRQ_MASK, 8'h01 << b);
      chk("irq_raised", 11'h001, 11'(irq_o));
      wr(ADDR_IRQ_STATUS, 8'h01 << b);
      ev <= 4'b0000;
      rc("irq_cleared", ADDR_IRQ_STATUS, 8'h00);
      chk("irq_low", 11'h000, 11'(irq_o));
    end
    // Set wins over a same-cycle clear
    @(posedge clk_i);
    ev <= 4'b0010;
    wr(ADDR_IRQ_STATUS, 8'h02);
    rc("irq_set_wins", ADDR_IRQ_STATUS, 8'h02);
    wr(ADDR_IRQ_STATUS, 8'h02);
    ev <= 4'b0000;
    rc("irq_set_wins_clear", ADDR_IRQ_STATUS, 8'h00);
  endtask : t_status
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #(100 * 20000);
    err_total++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_offset();
    t_ro();
    t_status();
    close_out();
  end
endmodule : aosr_regs_tb
bind aosr_regs aosr_regs_monitor i_mon (.*);
`default_nettype wire

// ---- rtl/aosr_offset_scale.sv ----
`timescale 1ns/100ps
`default_nettype none
module aosr_offset_scale
  import aosr_pkg::*;
(
  aosr_scale_if.dst sc
);
  // ----------------------------------------
  // Signed code times step, quarter LSb units
  // ----------------------------------------
  wire logic signed [10:0] code_ext;
  assign code_ext = 11'(signed'(sc.code));
  assign sc.scaled = (sc.step == STEP_TWO)  ? 11'(code_ext <<< 3) :
                     (sc.step == STEP_ONE)  ? 11'(code_ext <<< 2) :
                     (sc.step == STEP_HALF) ? 11'(code_ext <<< 1) : code_ext;
endmodule : aosr_offset_scale
`default_nettype wire

// ---- rtl/aosr_pkg.sv ----
package aosr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [8:0] ADDR_CH4_OFFSET    = 9'h0_A2;
  localparam logic [8:0] ADDR_CH5_OFFSET    = 9'h0_A3;
  localparam logic [8:0] ADDR_CH6_OFFSET    = 9'h0_A4;
  localparam logic [8:0] ADDR_CH7_OFFSET    = 9'h0_A5;
  localparam logic [8:0] ADDR_STEP_CTRL     = 9'h0_A7;
  localparam logic [8:0] ADDR_CAL_STATUS    = 9'h0_C0;
  localparam logic [8:0] ADDR_PLL_STATUS    = 9'h0_D1;
  localparam logic [8:0] ADDR_IRQ_STATUS    = 9'h0_E0;
  localparam logic [8:0] ADDR_IRQ_MASK      = 9'h0_E1;
  localparam logic [8:0] ADDR_IDENT_LOW     = 9'h1_5C;
  localparam logic [8:0] ADDR_IDENT_HIGH    = 9'h1_5D;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int         STEP_SEL_LSB       = 3;
  localparam int         STEP_SEL_MSB       = 4;
  localparam logic [7:0] STEP_CTRL_RESET    = 8'h47;
  localparam logic [7:0] OFFSET_RESET       = 8'h00;
  localparam int         CAL_DONE_BIT       = 7;
  localparam int         PLL_CAL_DONE_BIT   = 5;
  localparam int         PLL_DRIFT_LOW_BIT  = 2;
  localparam int         PLL_DRIFT_HIGH_BIT = 1;
  localparam logic [6:0] CAL_RSVD_VALUE     = 7'h00;
  localparam logic [7:0] PLL_RSVD_VALUE     = 8'h00;
  // Arbitrary neutral identification value
  localparam logic [15:0] DEVICE_IDENT      = 16'h1234;

  // ----------------------------------------
  // Interrupt status layout
  // ----------------------------------------
  localparam int IRQ_CAL_DONE    = 0;
  localparam int IRQ_PLL_DONE    = 1;
  localparam int IRQ_DRIFT_LOW   = 2;
  localparam int IRQ_DRIFT_HIGH  = 3;
  localparam int IRQ_W           = 4;

  // Step selection codes, quarter LSb units
  typedef enum logic [1:0] {
    STEP_QUARTER = 2'h0,
    STEP_HALF    = 2'h1,
    STEP_ONE     = 2'h2,
    STEP_TWO     = 2'h3
  } aosr_step_t;

endpackage : aosr_pkg

// ---- rtl/aosr_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Four 8-bit channel offsets, reset zero
// - Offset equals code times step size
// - Step field bits 4:3 selects step
// - One step setting for all offsets
// - Calibration done flag in bit 7
// - Factory status bits are read-only
// - PLL calibration done in bit 5
// - Bit 2 flags low drift
// - Bit 1 flags high drift
// - 16-bit ident, low byte first
// - Offset code is two's complement
module aosr_regs
  import aosr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [8:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        cal_done_i,
  input  wire logic        pll_cal_done_i,
  input  wire logic        pll_drift_low_i,
  input  wire logic        pll_drift_high_i,
  input  wire logic [1:0]  chan_sel_i,
  output logic      [10:0] chan_offset_o,
  output logic      [1:0]  step_sel_o,
  output logic             irq_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0]        offset_ff [4];
  logic [7:0]        step_ctrl_ff;
  logic              cal_done_ff;
  logic              pll_done_ff;
  logic              drift_low_ff;
  logic              drift_high_ff;
  logic [IRQ_W-1:0]  irq_stat_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;
  logic [IRQ_W-1:0]  prev_ev_ff;
  logic [7:0]        rdata_ff;
  logic [10:0]       chan_offset_ff;
  logic              irq_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic             hit_ch4;
  wire logic             hit_ch5;
  wire logic             hit_ch6;
  wire logic             hit_ch7;
  wire logic             wr_step;
  wire logic             wr_istat;
  wire logic             wr_imask;
  wire logic [3:0]       wr_chan;
  wire logic [IRQ_W-1:0] ev_now;
  wire logic [IRQ_W-1:0] ev_rise;
  wire logic [IRQ_W-1:0] nxt_irq_stat;
  wire logic [7:0]       nxt_rdata;
  wire logic [7:0]       cal_reg;
  logic      [7:0]       pll_reg;

  assign hit_ch4  = (addr_i == ADDR_CH4_OFFSET);
  assign hit_ch5  = (addr_i == ADDR_CH5_OFFSET);
  assign hit_ch6  = (addr_i == ADDR_CH6_OFFSET);
  assign hit_ch7  = (addr_i == ADDR_CH7_OFFSET);
  assign wr_chan  = {hit_ch7, hit_ch6, hit_ch5, hit_ch4} & {4{wr_i}};
  assign wr_step  = wr_i && (addr_i == ADDR_STEP_CTRL);
  assign wr_istat = wr_i && (addr_i == ADDR_IRQ_STATUS);
  assign wr_imask = wr_i && (addr_i == ADDR_IRQ_MASK);

  assign cal_reg = {cal_done_ff, CAL_RSVD_VALUE};

  always_comb begin
    pll_reg                     = PLL_RSVD_VALUE;
    pll_reg[PLL_CAL_DONE_BIT]   = pll_done_ff;
    pll_reg[PLL_DRIFT_LOW_BIT]  = drift_low_ff;
    pll_reg[PLL_DRIFT_HIGH_BIT] = drift_high_ff;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // ident byte order
  assign nxt_rdata = !rd_i                        ? 8'h00 :
                     hit_ch4                      ? offset_ff[0] :
                     hit_ch5                      ? offset_ff[1] :
                     hit_ch6                      ? offset_ff[2] :
                     hit_ch7                      ? offset_ff[3] :
                     (addr_i == ADDR_STEP_CTRL)   ? step_ctrl_ff :
                     (addr_i == ADDR_CAL_STATUS)  ? cal_reg :
                     (addr_i == ADDR_PLL_STATUS)  ? pll_reg :
                     (addr_i == ADDR_IRQ_STATUS)  ? 8'(irq_stat_ff) :
                     (addr_i == ADDR_IRQ_MASK)    ? 8'(irq_mask_ff) :
                     (addr_i == ADDR_IDENT_LOW)   ? DEVICE_IDENT[7:0] :
                     (addr_i == ADDR_IDENT_HIGH)  ? DEVICE_IDENT[15:8] : 8'h00;

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  assign ev_now = {drift_high_ff, drift_low_ff, pll_done_ff, cal_done_ff};
  assign ev_rise = ev_now & ~prev_ev_ff;
  // Set wins over a write-one clear
  assign nxt_irq_stat = (irq_stat_ff & ~(wr_istat ? wdata_i[IRQ_W-1:0] : '0)) | ev_rise;

  // ----------------------------------------
  // Offset scaling, shared step field
  // ----------------------------------------
  aosr_scale_if sc ();
  assign sc.code = offset_ff[chan_sel_i];
  assign sc.step = step_ctrl_ff[STEP_SEL_MSB:STEP_SEL_LSB];

  aosr_offset_scale u_scale (
    .sc (sc)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // offset registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        offset_ff[i] <= OFFSET_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_chan[i]) begin
          offset_ff[i] <= wdata_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_ctrl_ff <= STEP_CTRL_RESET;
    end else if (wr_step) begin
      step_ctrl_ff <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_done_ff   <= 1'b0;
      pll_done_ff   <= 1'b0;
      drift_low_ff  <= 1'b0;
      drift_high_ff <= 1'b0;
    end else begin
      cal_done_ff   <= cal_done_i;
      pll_done_ff   <= pll_cal_done_i;
      drift_low_ff  <= pll_drift_low_i;
      drift_high_ff <= pll_drift_high_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_ff    <= '0;
      irq_mask_ff    <= '0;
      prev_ev_ff     <= '0;
      irq_ff         <= 1'b0;
      rdata_ff       <= 8'h00;
      chan_offset_ff <= 11'h000;
    end else begin
      irq_stat_ff    <= nxt_irq_stat;
      prev_ev_ff     <= ev_now;
      irq_ff         <= |(nxt_irq_stat & irq_mask_ff);
      rdata_ff       <= nxt_rdata;
      chan_offset_ff <= sc.scaled;
      if (wr_imask) begin
        irq_mask_ff <= wdata_i[IRQ_W-1:0];
      end
    end
  end

  assign rdata_o       = rdata_ff;
  assign chan_offset_o = chan_offset_ff;
  assign step_sel_o    = step_ctrl_ff[STEP_SEL_MSB:STEP_SEL_LSB];
  assign irq_o         = irq_ff;

endmodule : aosr_regs
`default_nettype wire

// ---- rtl/aosr_scale_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface aosr_scale_if;
  logic [7:0]  code;
  logic [1:0]  step;
  logic [10:0] scaled;
  modport src (output code, output step, input scaled);
  modport dst (input code, input step, output scaled);
endinterface : aosr_scale_if
`default_nettype wire
